/* File: rvtg_cfg.svh */
// constants of the raster video timing generator: offsets, fields, reset values, counts
`ifndef RVTG_CFG_SVH
`define RVTG_CFG_SVH
// ==========================================================
// register byte offsets
`define RVTG_OFF_HALFSYNC 8'h00
`define RVTG_OFF_BACKPORCH 8'h04
`define RVTG_OFF_DISPLAY 8'h08
`define RVTG_OFF_SHORTDISP 8'h0c
`define RVTG_OFF_BROADPULSE 8'h10
`define RVTG_OFF_LINETIME 8'h14
`define RVTG_OFF_VERTICAL_DISPLAY_LENGTH 8'h18
`define RVTG_OFF_PREEQ 8'h1c
`define RVTG_OFF_POSTEQ 8'h20
`define RVTG_OFF_VSYNC 8'h24
`define RVTG_OFF_VERTICAL_BLANK_LENGTH 8'h28
`define RVTG_OFF_XFERDLY 8'h2c
`define RVTG_OFF_CTRL 8'h40
`define RVTG_OFF_STATUS 8'h44
// ==========================================================
// control register fields
`define RVTG_CTRL_EN 0
`define RVTG_CTRL_INTERLACE 1
`define RVTG_CTRL_SLAVE 2
`define RVTG_CTRL_SYNC_OFF 6
`define RVTG_CTRL_DLY_LO 8
`define RVTG_CTRL_DLY_HI 10
`define RVTG_CTRL_BLANK_OFF 11
// ==========================================================
// status register fields
`define RVTG_STAT_FLYBACK 0
`define RVTG_STAT_FIELD 1
`define RVTG_STAT_RUN 2
// ==========================================================
// reset values and counts
`define RVTG_PARAM_RST 12'h002
`define RVTG_CTRL_RST 12'h000
`define RVTG_NUM_PARAMS 12
`define RVTG_REG_UNMAPPED 4'hf
`define RVTG_PIX_PER_UNIT 4
`define RVTG_DLY_TAPS 8
`endif

/* File: rvtg_core.sv */
// raster video timing generator with ahb-lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "rvtg_cfg.svh"
// How it works
// RULE1 - line in four-pixel units, frame in half-lines
// RULE2 - display length visible, rest of line blanked
// RULE3 - no front porch; line ends at linetime
// RULE4 - line sync is two halfsync periods
// RULE5 - vertical display counted in half lines
// RULE6 - blanking phases in half lines, summed
// RULE7 - vsync low broadpulse, equalise low halfsync
// RULE8 - vsync and equalisation lines last half a linetime
// RULE9 - vsync serration high is remainder of half-line
// RULE10 - host keeps every parameter above one
// RULE11 - host keeps linetime even in pixel clocks
// RULE12 - host keeps half linetime within bounds
// RULE13 - host programs whole, interlace odd, lines
// RULE14 - host keeps back porch above transfer delay
// RULE15 - host keeps transfer delay below short display
// RULE16 - host touches parameters only while disabled
// RULE17 - host boots, then clears control bit 0
// RULE18 - enable starts frame at frame sync
// RULE19 - host disables, rewrites, re-enables to reprogram
// RULE20 - mode change allowed while enabled
// RULE21 - control bits 6 and 11 gate dac sync/blank
// RULE22 - sync and blank delayed one to eight cycles
// RULE23 - flyback flag in frame flyback; blank both flybacks
// RULE24 - master drives syncs, slave locks to them
// RULE25 - state counter per unit, ends at parameter
module rvtg_core
	import rvtg_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// sync pins, two-way: inputs used in slave mode
	input wire logic vsync_n_i,
	input wire logic csync_n_i,
	output logic vsync_n_o,
	output logic csync_n_o,
	output logic sync_oe_o,
	// internal video converter feeds
	output logic dac_sync_n_o,
	output logic dac_blank_o,
	output logic composite_blank_o,
	output logic frame_flyback_flag_o
);
	// ==========================================================
	// register decode, shared by read and write paths
	function automatic logic [3:0] reg_index(input logic [7:0] a);
		case (a)
			`RVTG_OFF_HALFSYNC: reg_index = 4'h0;
			`RVTG_OFF_BACKPORCH: reg_index = 4'h1;
			`RVTG_OFF_DISPLAY: reg_index = 4'h2;
			`RVTG_OFF_SHORTDISP: reg_index = 4'h3;
			`RVTG_OFF_BROADPULSE: reg_index = 4'h4;
			`RVTG_OFF_LINETIME: reg_index = 4'h5;
			`RVTG_OFF_VERTICAL_DISPLAY_LENGTH: reg_index = 4'h6;
			`RVTG_OFF_PREEQ: reg_index = 4'h7;
			`RVTG_OFF_POSTEQ: reg_index = 4'h8;
			`RVTG_OFF_VSYNC: reg_index = 4'h9;
			`RVTG_OFF_VERTICAL_BLANK_LENGTH: reg_index = 4'ha;
			`RVTG_OFF_XFERDLY: reg_index = 4'hb;
			`RVTG_OFF_CTRL: reg_index = 4'hc;
			`RVTG_OFF_STATUS: reg_index = 4'hd;
			default: reg_index = `RVTG_REG_UNMAPPED;
		endcase
	endfunction
	// ==========================================================
	// declarations
	logic [11:0] param_r [0:`RVTG_NUM_PARAMS-1]; // timing parameters
	logic [11:0] ctrl_r; // control register
	logic wr_pend_r; // write data phase pending
	logic [3:0] wr_idx_r; // index latched in address phase
	logic addr_ok; // valid address phase
	logic [3:0] a_idx; // decoded index of haddr
	logic [31:0] rd_val; // read value of a_idx
	logic [1:0] pre_r; // pixel prescaler to screen units
	logic tick; // one screen unit elapsed
	rvtg_lstate_t lst_r; // line segment state
	rvtg_phase_t ph_r; // frame phase
	logic [11:0] ucnt_r; // units spent in current state
	logic [13:0] pcnt_r; // pixels since line start
	logic [12:0] hcnt_r; // half-lines spent in phase
	logic run_r; // generator running
	logic field_r; // interlace field
	logic vs_d_r; // previous external frame sync
	logic hs_d_r; // previous external line sync
	logic ext_vs; // external frame sync fell
	logic ext_hs; // external line sync fell
	logic [11:0] plen; // length of current phase
	logic [12:0] hrem; // half-lines left in phase
	logic half; // this line is a half line
	logic [13:0] lend; // last pixel of the line
	logic line_end; // line finishes this clock
	logic [12:0] hinc; // half-lines the line consumes
	logic [11:0] slen; // length of current state
	logic seg_end; // state finishes this clock
	logic eq_line; // equalisation half-line
	rvtg_vid_t vid; // raw video timing
	rvtg_vid_t vid_dly; // delayed video timing
	// ==========================================================
	// ahb-lite slave: zero wait, always okay
	assign addr_ok = hsel_i & hready_i & htrans_i[1];
	assign a_idx = reg_index(haddr_i[7:0]);
	// read value of the addressed register; unmapped reads zero
	always_comb
	begin
		rd_val = 32'h0000_0000;
		if (a_idx < 4'hc)
			rd_val = {20'h0_0000, param_r[a_idx]};
		else if (a_idx == 4'hc)
			rd_val = {20'h0_0000, ctrl_r};
		else if (a_idx == 4'hd)
		begin
			rd_val[`RVTG_STAT_FLYBACK] = ~ph_r[3];
			rd_val[`RVTG_STAT_FIELD] = field_r;
			rd_val[`RVTG_STAT_RUN] = run_r;
			rd_val[12:8] = ph_r;
		end
		// a read right behind a write to the same word sees the new value
		if (wr_pend_r && wr_idx_r == a_idx && a_idx < 4'hd)
			rd_val = {20'h0_0000, hwdata_i[11:0]};
	end
	// address phase capture; read data prepared for the data phase
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			wr_pend_r <= 1'b0;
			wr_idx_r <= `RVTG_REG_UNMAPPED;
			hrdata_o <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			if (hready_i)
			begin
				wr_pend_r <= addr_ok & hwrite_i;
				wr_idx_r <= a_idx;
			end
			if (addr_ok & ~hwrite_i)
				hrdata_o <= rd_val;
		end
	end
	// slave never stalls and never errors
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
		else
		begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end
	// ==========================================================
	// register writes in the data phase; hsize is word only
	// writes while enabled are taken too (see RULE16), so careless
	// software sees a glitched frame rather than a locked bus
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < `RVTG_NUM_PARAMS; i++)
				param_r[i] <= `RVTG_PARAM_RST;
			ctrl_r <= `RVTG_CTRL_RST;
		end
		else if (ce_i && wr_pend_r)
		begin
			if (wr_idx_r < 4'hc)
				param_r[wr_idx_r] <= hwdata_i[11:0];
			else if (wr_idx_r == 4'hc)
				ctrl_r <= hwdata_i[11:0]; // see RULE20
		end
	end
	// ==========================================================
	// phase length and line shape
	always_comb
	begin
		case (ph_r)
			RVTG_PH_VS: plen = param_r[9];
			RVTG_PH_POST: plen = param_r[8];
			RVTG_PH_VBL: plen = param_r[10];
			RVTG_PH_DISP: plen = param_r[6]; // see RULE5
			RVTG_PH_PRE: plen = param_r[7];
			default: plen = param_r[9];
		endcase
	end
	assign hrem = {1'b0, plen} - hcnt_r; // see RULE6
	// vsync and equalisation lines and an odd last half-line of any phase are short
	assign half = ~(ph_r[2] | ph_r[3]) | (hrem == 13'h0001); // see RULE8
	// linetime/2 = linetime*2 pixels; full line = linetime*4 pixels
	assign lend = half ? ({1'b0, param_r[5], 1'b0} - 14'h0001)
		: ({param_r[5], 2'b00} - 14'h0001); // see RULE3
	assign line_end = run_r & (pcnt_r == lend);
	assign hinc = half ? 13'h0001 : 13'h0002;
	assign eq_line = ph_r[0] ? 1'b0 : ~(ph_r[2] | ph_r[3]);
	// per-state length in screen units
	always_comb
	begin
		case (lst_r)
			RVTG_L_HS1: slen = param_r[0]; // see RULE4
			RVTG_L_HS2: slen = param_r[0];
			RVTG_L_BP: slen = param_r[1];
			RVTG_L_DISP: slen = eq_line ? param_r[3] : param_r[2]; // see RULE8
			RVTG_L_BROAD: slen = param_r[4]; // see RULE7
			default: slen = 12'hfff;
		endcase
	end
	assign seg_end = tick & (ucnt_r + 12'h001 == slen) & ~lst_r[4]; // see RULE25
	// ==========================================================
	// external sync edges for slave mode
	assign ext_vs = vs_d_r & ~vsync_n_i;
	assign ext_hs = hs_d_r & ~csync_n_i;
	// previous pin levels for edge detection
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			vs_d_r <= 1'b1;
			hs_d_r <= 1'b1;
		end
		else if (ce_i)
		begin
			vs_d_r <= vsync_n_i;
			hs_d_r <= csync_n_i;
		end
	end
	// ==========================================================
	// run control and screen unit prescaler
	assign tick = run_r & (pre_r == 2'h3); // see RULE1
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			run_r <= 1'b0;
			pre_r <= 2'h0;
		end
		else if (ce_i)
		begin
			run_r <= ctrl_r[`RVTG_CTRL_EN];
			// prescaler realigns on line end, stop and slave line sync, not on slave frame sync alone
			if (~run_r | line_end)
				pre_r <= 2'h0;
			else if (ctrl_r[`RVTG_CTRL_SLAVE] & ext_hs)
				pre_r <= 2'h0;
			else
				pre_r <= pre_r + 2'h1;
		end
	end
	// ==========================================================
	// line state machine and pixel position
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			lst_r <= RVTG_L_BROAD;
			ucnt_r <= 12'h000;
			pcnt_r <= 14'h0000;
		end
		else if (ce_i)
		begin
			if (~run_r | line_end
				| (ctrl_r[`RVTG_CTRL_SLAVE] & (ext_hs | ext_vs)))
			begin
				// new line: vsync lines start with the broad pulse
				pcnt_r <= 14'h0000;
				ucnt_r <= 12'h000;
				if (~run_r | ext_vs)
					lst_r <= RVTG_L_BROAD; // see RULE18
				else if (line_end & hrem <= hinc & ph_r[4])
					lst_r <= RVTG_L_BROAD;
				else if (ph_r[0] & ~(line_end & hrem <= hinc))
					lst_r <= RVTG_L_BROAD;
				else
					lst_r <= RVTG_L_HS1;
			end
			else
			begin
				pcnt_r <= pcnt_r + 14'h0001;
				if (seg_end)
				begin
					ucnt_r <= 12'h000;
					case (lst_r)
						// equalisation low is a single halfsync
						RVTG_L_HS1: lst_r <= eq_line ? RVTG_L_BP : RVTG_L_HS2; // see RULE7
						RVTG_L_HS2: lst_r <= RVTG_L_BP;
						RVTG_L_BP: lst_r <= RVTG_L_DISP;
						RVTG_L_DISP: lst_r <= RVTG_L_FP; // see RULE2
						RVTG_L_BROAD: lst_r <= RVTG_L_FP; // see RULE9
						default: lst_r <= RVTG_L_FP;
					endcase
				end
				else if (tick)
					ucnt_r <= ucnt_r + 12'h001;
			end
		end
	end
	// ==========================================================
	// frame phase sequencer, counted in half-lines
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			ph_r <= RVTG_PH_VS;
			hcnt_r <= 13'h0000;
			field_r <= 1'b0;
		end
		else if (ce_i)
		begin
			if (~run_r | (ctrl_r[`RVTG_CTRL_SLAVE] & ext_vs))
			begin
				ph_r <= RVTG_PH_VS; // see RULE18
				hcnt_r <= 13'h0000;
				if (~run_r)
					field_r <= 1'b0;
			end
			else if (line_end)
			begin
				if (hrem <= hinc)
				begin
					hcnt_r <= 13'h0000;
					case (ph_r)
						RVTG_PH_VS: ph_r <= RVTG_PH_POST;
						RVTG_PH_POST: ph_r <= RVTG_PH_VBL;
						RVTG_PH_VBL: ph_r <= RVTG_PH_DISP;
						RVTG_PH_DISP: ph_r <= RVTG_PH_PRE;
						RVTG_PH_PRE: ph_r <= RVTG_PH_VS;
						default: ph_r <= RVTG_PH_VS;
					endcase
					if (ph_r[4] & ctrl_r[`RVTG_CTRL_INTERLACE])
						field_r <= ~field_r;
				end
				else
					hcnt_r <= hcnt_r + hinc;
			end
		end
	end
	// ==========================================================
	// raw timing: sync low in hs1, hs2 and broad pulse
	always_comb
	begin
		vid.csync_n = ~(run_r & (lst_r[0] | lst_r[1] | lst_r[5]));
		vid.vsync_n = ~(run_r & ph_r[0]);
		vid.blank = ~(run_r & ph_r[3] & lst_r[3]); // see RULE23
		vid.flyback = ~ph_r[3] | ~run_r; // see RULE23
	end
	// ==========================================================
	// pipeline matching delay
	rvtg_dly u_dly (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.sel_i(ctrl_r[`RVTG_CTRL_DLY_HI:`RVTG_CTRL_DLY_LO]), // see RULE22
		.d_i(vid),
		.q_o(vid_dly)
	);
	// ==========================================================
	// registered outputs; pins are driven only in master mode
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			vsync_n_o <= 1'b1;
			csync_n_o <= 1'b1;
			sync_oe_o <= 1'b0;
			dac_sync_n_o <= 1'b1;
			dac_blank_o <= 1'b1;
			composite_blank_o <= 1'b1;
			frame_flyback_flag_o <= 1'b1;
		end
		else if (ce_i)
		begin
			vsync_n_o <= vid.vsync_n;
			csync_n_o <= vid.csync_n;
			sync_oe_o <= ~ctrl_r[`RVTG_CTRL_SLAVE]; // see RULE24
			// disabled feeds rest inactive at the converters
			dac_sync_n_o <= vid_dly.csync_n | ctrl_r[`RVTG_CTRL_SYNC_OFF]; // see RULE21
			dac_blank_o <= vid_dly.blank & ~ctrl_r[`RVTG_CTRL_BLANK_OFF]; // see RULE21
			composite_blank_o <= vid.blank;
			frame_flyback_flag_o <= vid.flyback;
		end
	end
endmodule // rvtg_core
`default_nettype wire

/* File: rvtg_core_monitor.sv */
// port-level checker for the raster video timing generator core
`timescale 1ns/1ns
`default_nettype none
`include "rvtg_cfg.svh"
module rvtg_core_chk
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic csync_n_o,
	input wire logic vsync_n_o,
	input wire logic sync_oe_o,
	input wire logic dac_sync_n_o,
	input wire logic dac_blank_o,
	input wire logic composite_blank_o,
	input wire logic frame_flyback_flag_o
);
	// ==========================================================
	// shadows of the bus writes
	logic wr_ph_r; // a write data phase is pending
	logic [7:0] adr_r; // its byte offset
	logic [11:0] ctrl_r; // control word copy
	logic [11:0] hs_r; // half-sync copy
	logic [11:0] bw_r; // broad pulse copy
	logic [9:0] age_r; // clocks since control write, saturating
	logic [15:0] lo_r; // length of current sync low run
	// follows writes; clock enable is held high by the bench
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			wr_ph_r <= 1'b0;
			adr_r <= 8'h00;
			ctrl_r <= `RVTG_CTRL_RST;
			hs_r <= `RVTG_PARAM_RST;
			bw_r <= `RVTG_PARAM_RST;
		end
		else if (hready_i)
		begin
			wr_ph_r <= hsel_i && htrans_i[1] && hwrite_i;
			adr_r <= haddr_i[7:0];
			if (wr_ph_r && adr_r == `RVTG_OFF_CTRL)
				ctrl_r <= hwdata_i[11:0];
			if (wr_ph_r && adr_r == `RVTG_OFF_HALFSYNC)
				hs_r <= hwdata_i[11:0];
			if (wr_ph_r && adr_r == `RVTG_OFF_BROADPULSE)
				bw_r <= hwdata_i[11:0];
		end
	end
	// settling timer: mode changes take a few clocks to reach the pins
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || (wr_ph_r && hready_i && adr_r == `RVTG_OFF_CTRL))
			age_r <= 10'h000;
		else if (age_r != 10'h3ff)
			age_r <= age_r + 10'h001;
	end
	// sync low run counter
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || csync_n_o)
			lo_r <= 16'h0000;
		else
			lo_r <= lo_r + 16'h0001;
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o) else $error("bus slave stalled or errored");
	AST_BLANK_FLY: assert property (frame_flyback_flag_o |-> composite_blank_o)
		else $error("flyback without blank");
	AST_VS_FLY: assert property (!vsync_n_o |-> frame_flyback_flag_o)
		else $error("frame sync outside flyback");
	AST_STOPPED: assert property (age_r >= 4 && !ctrl_r[0] |-> composite_blank_o && frame_flyback_flag_o
		&& csync_n_o && vsync_n_o) else $error("stopped generator not idle");
	AST_SYNC_OFF: assert property (age_r >= 12 && ctrl_r[6] |-> dac_sync_n_o)
		else $error("converter sync not gated");
	AST_BLANK_OFF: assert property (age_r >= 12 && ctrl_r[11] |-> !dac_blank_o)
		else $error("converter blank not gated");
	AST_DLY0: assert property (age_r >= 12 && ctrl_r[10:8] == 3'h0 && !ctrl_r[6]
		|-> dac_sync_n_o == $past(csync_n_o, 1)) else $error("converter sync lag wrong at zero delay");
	AST_DLY7: assert property (age_r >= 12 && ctrl_r[10:8] == 3'h7 && !ctrl_r[6]
		|-> dac_sync_n_o == $past(csync_n_o, 8)) else $error("converter sync lag wrong at full delay");
	AST_PULSE_W: assert property ($rose(csync_n_o) && ctrl_r[0] && !ctrl_r[2] && age_r >= 64
		|-> lo_r == 16'(hs_r * 4) || lo_r == 16'(hs_r * 8) || lo_r == 16'(bw_r * 4)) else $error("sync low width");
	AST_OE_SLAVE: assert property (sync_oe_o |-> !ctrl_r[2] || age_r < 4)
		else $error("pins driven in slave mode");
endmodule // rvtg_core_chk
bind rvtg_core rvtg_core_chk chk_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
	.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .csync_n_o(csync_n_o), .vsync_n_o(vsync_n_o),
	.sync_oe_o(sync_oe_o), .dac_sync_n_o(dac_sync_n_o), .dac_blank_o(dac_blank_o),
	.composite_blank_o(composite_blank_o), .frame_flyback_flag_o(frame_flyback_flag_o));
`default_nettype wire

/* File: rvtg_dly.sv */
// programmable 1..8 cycle delay for sync and blank
`timescale 1ns/1ns
`default_nettype none
`include "rvtg_cfg.svh"
module rvtg_dly
	import rvtg_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [2:0] sel_i,
	input wire rvtg_vid_t d_i,
	output rvtg_vid_t q_o
);
	// ==========================================================
	// tap chain; tap 0 is the undelayed input
	rvtg_vid_t tap [0:`RVTG_DLY_TAPS-1]; // delay taps
	rvtg_vid_t idle_v; // inactive video levels
	assign idle_v = '{csync_n: 1'b1, vsync_n: 1'b1, blank: 1'b1, flyback: 1'b1};
	assign tap[0] = d_i;
	genvar gi;
	generate
		for (gi = 1; gi < `RVTG_DLY_TAPS; gi = gi + 1)
		begin : g_tap
			rvtg_vid_t stage_r; // one cycle of delay
			// each stage shifts one clock later
			always_ff @(posedge core_clk_i)
			begin
				if (rst_i)
					stage_r <= idle_v;
				else if (ce_i)
					stage_r <= tap[gi-1];
			end
			assign tap[gi] = stage_r;
		end
	endgenerate
	// ==========================================================
	// output select, registered so the taps never glitch out
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			q_o <= idle_v;
		else if (ce_i)
			q_o <= tap[sel_i];
	end
endmodule // rvtg_dly
`default_nettype wire

/* File: rvtg_pkg.sv */
// types shared by the raster video timing generator files
package rvtg_pkg;
	// ==========================================================
	// video signals carried together through the delay line
	typedef struct packed {
		logic csync_n; // composite sync, low active
		logic vsync_n; // frame sync, low active
		logic blank; // composite blank
		logic flyback; // frame flyback flag
	} rvtg_vid_t;
	// line segment states, one-hot
	typedef enum logic [5:0] {
		RVTG_L_HS1 = 6'h01,
		RVTG_L_HS2 = 6'h02,
		RVTG_L_BP = 6'h04,
		RVTG_L_DISP = 6'h08,
		RVTG_L_FP = 6'h10,
		RVTG_L_BROAD = 6'h20
	} rvtg_lstate_t;
	// frame phases, one-hot
	typedef enum logic [4:0] {
		RVTG_PH_VS = 5'h01,
		RVTG_PH_POST = 5'h02,
		RVTG_PH_VBL = 5'h04,
		RVTG_PH_DISP = 5'h08,
		RVTG_PH_PRE = 5'h10
	} rvtg_phase_t;
endpackage

/* File: rvtg_sync_src.sv */
// external sync master standing on the sync pins in slave mode
`timescale 1ns/1ns
`default_nettype none
module rvtg_sync_src
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic oe_i,
	input wire logic vs_dev_i,
	input wire logic cs_dev_i,
	output logic vs_o,
	output logic cs_o
);
	logic [2:0] cnt_r; // low clocks left in the pulse
	// one pulse of four clocks per request
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			cnt_r <= 3'h0;
		else if (go_i)
			cnt_r <= 3'h4;
		else if (cnt_r != 3'h0)
			cnt_r <= cnt_r - 3'h1;
	end
	// pins idle high through pull-ups; a driving device wins the wire
	assign vs_o = oe_i ? vs_dev_i : (cnt_r == 3'h0);
	assign cs_o = oe_i ? cs_dev_i : (cnt_r == 3'h0);
endmodule // rvtg_sync_src
`default_nettype wire

/* File: tb_raster_video_timing_generator.sv */
// self-checking bench for the raster video timing generator
`timescale 1ns/1ns
`default_nettype none
`include "rvtg_cfg.svh"
module tb_raster_video_timing_generator;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1; // never frozen here
	logic hsel_i = 1'b1; // only slave on the bus
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [2:0] hsize_i = 3'h2; // whole words only
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] hrdata_o;
	logic hreadyout_o, hresp_o, csync_n_o, vsync_n_o, sync_oe_o;
	logic dac_sync_n_o, dac_blank_o, composite_blank_o, frame_flyback_flag_o;
	logic go = 1'b0; // fires an external sync pulse
	logic vs_pin, cs_pin; // resolved sync pin levels
	int miscompares = 0;
	int checked = 0;
	// legal set: half line 12 units, 2*hs+bp 9, back porch 20 clocks
	logic [11:0] pv [12] = '{12'h002, 12'h005, 12'h00a, 12'h002,
		12'h00a, 12'h018, 12'h004, 12'h003,
		12'h003, 12'h003, 12'h002, 12'h002};
	always #10 core_clk_i = ~core_clk_i;
	rvtg_core dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
		.vsync_n_i(vs_pin), .csync_n_i(cs_pin), .vsync_n_o(vsync_n_o), .csync_n_o(csync_n_o),
		.sync_oe_o(sync_oe_o), .dac_sync_n_o(dac_sync_n_o), .dac_blank_o(dac_blank_o),
		.composite_blank_o(composite_blank_o), .frame_flyback_flag_o(frame_flyback_flag_o));
	rvtg_sync_src ext_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .go_i(go), .oe_i(sync_oe_o),
		.vs_dev_i(vsync_n_o), .cs_dev_i(csync_n_o), .vs_o(vs_pin), .cs_o(cs_pin));
	// ==========================================================
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (e !== g)
		begin
			miscompares++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	// one single transfer; entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i <= {24'h0, a};
		@(posedge core_clk_i);
		while (hreadyout_o !== 1'b1) @(posedge core_clk_i);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		@(posedge core_clk_i);
		while (hreadyout_o !== 1'b1) @(posedge core_clk_i);
		q = hrdata_o;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return csync_n_o;
			1: return vsync_n_o;
			2: return composite_blank_o;
			default: return frame_flyback_flag_o;
		endcase
	endfunction
	// counts clocks while the chosen output stays at v, bounded
	task automatic run(input int s, input logic v, output logic [31:0] n);
		n = 0;
		while (pick(s) === v && n < 5000)
		begin
			n++;
			@(posedge core_clk_i);
		end
		// a wait that never ends is a failure, not a silent pass
		if (n == 5000)
			chk("wait limit", 32'h0, n);
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs();
		logic [31:0] q;
		bus(1'b0, `RVTG_OFF_CTRL, 32'h0, q);
		chk("control reset", {20'h0, `RVTG_CTRL_RST}, q);
		wr(`RVTG_OFF_CTRL, 32'h0);
		for (int i = 0; i < `RVTG_NUM_PARAMS; i++)
		begin
			bus(1'b0, 8'(i * 4), 32'h0, q);
			chk("param reset", {20'h0, `RVTG_PARAM_RST}, q);
			wr(8'(i * 4), {20'h0, pv[i]});
			bus(1'b0, 8'(i * 4), 32'h0, q);
			chk("param readback", {20'h0, pv[i]}, q);
		end
		wr(8'h30, 32'h0000_0fff);
		bus(1'b0, 8'h30, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		bus(1'b0, `RVTG_OFF_STATUS, 32'h0, q);
		chk("stopped status", 32'h1, q & 32'h5);
	endtask
	task automatic t_frame();
		logic [31:0] lo, hi, e, hl;
		hl = pv[5] * `RVTG_PIX_PER_UNIT / 2;
		wr(`RVTG_OFF_CTRL, 32'h1);
		run(0, 1'b1, lo);
		chk("start delay", 32'h1, 32'(lo < 4));
		chk("master drives pins", 32'h1, {31'h0, sync_oe_o});
		for (int k = 0; k < 4; k++)
		begin
			e = (k < 3 ? pv[4] : pv[0]) * `RVTG_PIX_PER_UNIT;
			run(0, 1'b0, lo);
			run(0, 1'b1, hi);
			chk("half line low", e, lo);
			chk("half line high", hl - e, hi);
		end
		run(1, 1'b1, lo);
		run(1, 1'b0, lo);
		chk("frame sync span", pv[9] * hl, lo);
		run(1, 1'b1, hi);
		chk("frame rest", (pv[6] + pv[7] + pv[8] + pv[10]) * hl, hi);
		run(3, 1'b1, lo);
		run(0, 1'b0, lo);
		chk("line sync", pv[0] * 8, lo);
		run(0, 1'b1, hi);
		chk("line rest", pv[5] * `RVTG_PIX_PER_UNIT - pv[0] * 8, hi);
		run(2, 1'b1, lo);
		run(2, 1'b0, lo);
		chk("visible span", pv[2] * `RVTG_PIX_PER_UNIT, lo);
		run(3, 1'b0, lo);
		run(3, 1'b1, lo);
		run(3, 1'b0, lo);
		chk("display field", pv[6] * hl, lo);
		bus(1'b0, `RVTG_OFF_STATUS, 32'h0, lo);
		chk("running status", 32'h1005, lo & 32'h1f07);
	endtask
	task automatic t_dac();
		logic [31:0] n;
		wr(`RVTG_OFF_CTRL, 32'h841);
		repeat (12) @(posedge core_clk_i);
		n = 0;
		repeat (800)
		begin
			@(posedge core_clk_i);
			if (dac_sync_n_o !== 1'b1 || dac_blank_o !== 1'b0)
				n++;
		end
		chk("converter gating", 32'h0, n);
		wr(`RVTG_OFF_CTRL, 32'h701);
		run(2, 1'b0, n);
		run(2, 1'b1, n);
		n = 0;
		while (dac_blank_o !== 1'b0 && n < 20)
		begin
			n++;
			@(posedge core_clk_i);
		end
		chk("blank delay", 32'h8, n);
	endtask
	task automatic t_slave();
		logic [31:0] lo;
		wr(`RVTG_OFF_CTRL, 32'h5);
		run(0, 1'b0, lo);
		repeat (2) @(posedge core_clk_i);
		chk("slave releases pins", 32'h0, {31'h0, sync_oe_o});
		go <= 1'b1;
		@(posedge core_clk_i);
		go <= 1'b0;
		run(0, 1'b1, lo);
		chk("restart delay", 32'h1, 32'(lo < 8));
		run(0, 1'b0, lo);
		chk("restart pulse", pv[4] * `RVTG_PIX_PER_UNIT, lo);
		wr(`RVTG_OFF_CTRL, 32'h0);
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial
	begin
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		#50;
		@(posedge core_clk_i);
		t_regs();
		t_frame();
		t_dac();
		t_slave();
		give_verdict();
	end
	initial
	begin
		#600000; // several times the expected run length
		miscompares++;
		give_verdict();
	end
endmodule // tb_raster_video_timing_generator
`default_nettype wire
